/* File: rtl/evt_fault_pkg.sv */
// shared constants, field layouts and helpers for the event counter / fault display block
package evt_fault_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int CNT_W = 16;
  localparam int DISP_W = 64;
  localparam int SEL_W = 8;
  localparam int CHAN_W = 16;
  localparam int FCODE_W = 8;
  localparam int MIC_W = 8;
  localparam int SYND_W = 7;
  localparam int BUS_W = 3;
  localparam int FADDR_W = 30;
  localparam int BADDR_W = 32;
  localparam int FLT_LO_W = 5;
  localparam int FLT_HI_W = 10;
  localparam int GATE_W = 3;
  localparam int NCNT = 4;

  // ****************************************
  // display select codes and control bits
  // ****************************************
  localparam logic [SEL_W-1:0] DSEL_FAULT = 8'h04;
  localparam logic [SEL_W-1:0] DSEL_BOUNDS = 8'h05;
  localparam logic [SEL_W-1:0] DSEL_COUNTERS = 8'h06;
  localparam int CTRL_HOLD_BIT = 8;
  localparam int HW_LSB = 5;
  localparam int GATE_JOB_SEL = 0;
  localparam int GATE_JOB_MODE = 1;
  localparam int GATE_MONITOR = 2;
  localparam int FCODE_EVT_IDX = 0;
  localparam logic [DISP_W-1:0] DISP_RESET = 64'h0000_0000_0000_0000;

  // fault bus codes
  localparam logic [BUS_W-1:0] BUS_IO = 3'h0;
  localparam logic [BUS_W-1:0] BUS_READ1 = 3'h1;
  localparam logic [BUS_W-1:0] BUS_READ2 = 3'h2;
  localparam logic [BUS_W-1:0] BUS_READ3 = 3'h3;
  localparam logic [BUS_W-1:0] BUS_SCALAR = 3'h4;
  localparam logic [BUS_W-1:0] BUS_IFETCH = 3'h5;

  // ****************************************
  // carriers
  // ****************************************
  // fault display word, msb first: addr 34-63, mic 26-33, faults 16-25, synd 9-15,
  // double 8, faults 3-7, bus 0-2
  typedef struct packed {
    logic [FADDR_W-1:0] addr;
    logic [MIC_W-1:0] mic;
    logic [FLT_HI_W-1:0] flt_hi;
    logic [SYND_W-1:0] synd;
    logic dbl;
    logic [FLT_LO_W-1:0] flt_lo;
    logic [BUS_W-1:0] bus;
  } fault_word_t;

  // first error-correction fault as captured
  typedef struct packed {
    logic [FADDR_W-1:0] addr;
    logic [BUS_W-1:0] bus;
    logic [SYND_W-1:0] synd;
    logic dbl;
  } secded_cap_t;

  // counter display word, msb first
  typedef struct packed {
    logic [CNT_W-1:0] second_high;
    logic [CNT_W-1:0] second_low;
    logic [CNT_W-1:0] first_high;
    logic [CNT_W-1:0] first_low;
  } cnt_word_t;

  // function select channel: mask above select
  typedef struct packed {
    logic [FCODE_W-1:0] mask;
    logic [FCODE_W-1:0] sel;
  } func_chan_t;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [BADDR_W-HW_LSB-1:0] half_word(input logic [BADDR_W-1:0] a);
    return a[BADDR_W-1:HW_LSB];
  endfunction : half_word

  function automatic logic fcode_match(input func_chan_t ch, input logic [FCODE_W-1:0] fc);
    return ((fc ^ ch.sel) & ch.mask) == '0;
  endfunction : fcode_match

endpackage : evt_fault_pkg

/* File: rtl/counter_pair.sv */
// two 16-bit event counters with optional chaining into one 32-bit counter
`timescale 1ns/1ps
`default_nettype none
module counter_pair
  import evt_fault_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_clr,
  input wire logic i_inc_lo,
  input wire logic i_inc_hi,
  input wire logic i_chain,
  output logic [W-1:0] o_cnt_lo,
  output logic [W-1:0] o_cnt_hi,
  output logic o_ovf_lo,
  output logic o_ovf_hi
);

  logic [W-1:0] lo_r;
  logic [W-1:0] hi_r;
  logic hi_step;

  // wrap detection; chained high steps in the same cycle the low wraps
  assign o_ovf_lo = i_inc_lo && (lo_r == '1);
  assign hi_step = i_chain ? o_ovf_lo : i_inc_hi;
  assign o_ovf_hi = hi_step && (hi_r == '1);

  // low counter; clear after display transfer wins over counting
  always_ff @(posedge i_clk) begin
    if (i_rst || i_clr) begin
      lo_r <= '0;
    end else if (i_inc_lo) begin
      lo_r <= lo_r + 1'b1;
    end
  end

  // high counter
  always_ff @(posedge i_clk) begin
    if (i_rst || i_clr) begin
      hi_r <= '0;
    end else if (hi_step) begin
      hi_r <= hi_r + 1'b1;
    end
  end

  assign o_cnt_lo = lo_r;
  assign o_cnt_hi = hi_r;

endmodule : counter_pair
`default_nettype wire

/* File: rtl/first_capture.sv */
// holds the first captured value until released by a clear
`timescale 1ns/1ps
`default_nettype none
module first_capture #(
  parameter int W = 32
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_capture,
  input wire logic [W-1:0] i_data,
  input wire logic i_release,
  output logic o_valid,
  output logic [W-1:0] o_data
);

  logic valid_r;
  logic [W-1:0] data_r;
  logic take;

  // a capture in the release cycle is kept, not lost
  assign take = i_capture && (!valid_r || i_release);

  // held flag
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      valid_r <= 1'b0;
    end else if (take) begin
      valid_r <= 1'b1;
    end else if (i_release) begin
      valid_r <= 1'b0;
    end
  end

  // held value; cleared on release so the display reads zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      data_r <= '0;
    end else if (take) begin
      data_r <= i_data;
    end else if (i_release) begin
      data_r <= '0;
    end
  end

  assign o_valid = valid_r;
  assign o_data = data_r;

endmodule : first_capture
`default_nettype wire

/* File: rtl/event_counters_fault_display.sv */
// monitoring counters, fault capture and display register of the cpu
`timescale 1ns/1ps
`default_nettype none

module event_counters_fault_display
  import evt_fault_pkg::*;
#(
  parameter int EVT_N = 16,
  parameter int EVS_W = 4
) (
  input wire logic I_MCLK,
  input wire logic I_SRST,
  // display register access
  input wire logic [SEL_W-1:0] I_DISP_SEL,
  input wire logic I_DISP_RD,
  output logic [DISP_W-1:0] O_DISP_DATA,
  output logic O_DISP_VALID,
  // counter control from the maintenance unit
  input wire logic [CHAN_W-1:0] I_COUNTER_CONTROL_CHANNEL,
  input wire logic [CHAN_W-1:0] I_FUNCTION_SELECT_CHANNEL,
  input wire logic [EVT_N-1:0] I_EVENT_LINES,
  input wire logic [EVS_W-1:0] I_SEL_FIRST_LOW,
  input wire logic [EVS_W-1:0] I_SEL_FIRST_HIGH,
  input wire logic [EVS_W-1:0] I_SEL_SECOND_LOW,
  input wire logic [EVS_W-1:0] I_SEL_SECOND_HIGH,
  input wire logic [NCNT-1:0] I_COUNT_LINE,
  input wire logic I_CARRY_FIRST,
  input wire logic I_CARRY_SECOND,
  input wire logic [NCNT-1:0] I_STOP_EN,
  input wire logic I_STOP_RELEASE,
  output logic O_CPU_HALT,
  // gates
  input wire logic [GATE_W-1:0] I_GATE_MASK,
  input wire logic I_JOB_CNT_EN,
  input wire logic I_JOB_MODE,
  input wire logic I_MONITOR_MODE,
  // instruction issue for function-code counting
  input wire logic I_INSTR_ISSUE,
  input wire logic [FCODE_W-1:0] I_INSTR_FCODE,
  // error-correction faults
  input wire logic I_SECDED_ERR,
  input wire logic I_SECDED_DOUBLE,
  input wire logic [SYND_W-1:0] I_SECDED_SYND,
  input wire logic [BUS_W-1:0] I_SECDED_BUS,
  input wire logic [FADDR_W-1:0] I_SECDED_ADDR,
  // other fault conditions and live microcode address
  input wire logic [FLT_LO_W-1:0] I_FAULT_LO,
  input wire logic [FLT_HI_W-1:0] I_FAULT_HI,
  input wire logic [MIC_W-1:0] I_MIC_ADDR,
  input wire logic I_CLR_FAULT,
  input wire logic I_CLR_SINGLE,
  // bounds checking
  input wire logic I_MEM_ACCESS,
  input wire logic [BADDR_W-1:0] I_ACCESS_ADDR,
  input wire logic [BADDR_W-1:0] I_BOUND_LO,
  input wire logic [BADDR_W-1:0] I_BOUND_HI
);

  // ****************************************
  // declarations
  // ****************************************
  logic [EVT_N-1:0] events;
  logic fcode_event;
  logic gate_ok;
  logic [NCNT-1:0] evt_sel;
  logic [NCNT-1:0] inc;
  logic hold_counts;
  logic cnt_clr;
  logic [CNT_W-1:0] first_low_counter;
  logic [CNT_W-1:0] first_high_counter;
  logic [CNT_W-1:0] second_low_counter;
  logic [CNT_W-1:0] second_high_counter;
  logic [NCNT-1:0] ovf;
  logic [NCNT-1:0] stop_cond;
  logic halt_r;
  logic halt_nxt;
  logic [FLT_LO_W-1:0] flt_lo_r;
  logic [FLT_HI_W-1:0] flt_hi_r;
  secded_cap_t secded_in;
  secded_cap_t secded_held;
  logic secded_valid;
  logic bounds_hit;
  logic [BADDR_W-1:0] bounds_addr;
  logic bounds_valid;
  fault_word_t fault_word;
  cnt_word_t cnt_word;
  logic [DISP_W-1:0] disp_r;
  logic [DISP_W-1:0] disp_nxt;
  logic disp_valid_r;
  func_chan_t func_chan;

  // ****************************************
  // event lines and gates
  // ****************************************

  // function-code match replaces the lowest shared event line
  assign func_chan = func_chan_t'(I_FUNCTION_SELECT_CHANNEL);
  assign fcode_event = I_INSTR_ISSUE && fcode_match(func_chan, I_INSTR_FCODE);

  // both pairs see the same shared event lines
  always_comb begin
    events = I_EVENT_LINES;
    events[FCODE_EVT_IDX] = fcode_event;
  end

  // any one enabled gate condition allows counting
  assign gate_ok = (I_GATE_MASK[GATE_JOB_SEL] && I_JOB_CNT_EN)
                || (I_GATE_MASK[GATE_JOB_MODE] && I_JOB_MODE)
                || (I_GATE_MASK[GATE_MONITOR] && I_MONITOR_MODE);

  // per-counter event selection; the unit parks count lines low while reselecting
  assign evt_sel[0] = events[I_SEL_FIRST_LOW];
  assign evt_sel[1] = events[I_SEL_FIRST_HIGH];
  assign evt_sel[2] = events[I_SEL_SECOND_LOW];
  assign evt_sel[3] = events[I_SEL_SECOND_HIGH];

  // increment needs event, count line and a gate
  assign inc = evt_sel & I_COUNT_LINE & {NCNT{gate_ok}};

  // ****************************************
  // counters
  // ****************************************

  // zero after the counter display transfer unless held by control bit
  assign hold_counts = I_COUNTER_CONTROL_CHANNEL[CTRL_HOLD_BIT];
  assign cnt_clr = I_DISP_RD && (I_DISP_SEL == DSEL_COUNTERS) && !hold_counts;

  // first pair; carry only within the pair
  counter_pair #(
    .W(CNT_W)
  ) u_first_pair (
    .i_clk(I_MCLK),
    .i_rst(I_SRST),
    .i_clr(cnt_clr),
    .i_inc_lo(inc[0]),
    .i_inc_hi(inc[1]),
    .i_chain(I_CARRY_FIRST),
    .o_cnt_lo(first_low_counter),
    .o_cnt_hi(first_high_counter),
    .o_ovf_lo(ovf[0]),
    .o_ovf_hi(ovf[1])
  );

  // second pair, own carry control; clear and gate shared with the first
  counter_pair #(
    .W(CNT_W)
  ) u_second_pair (
    .i_clk(I_MCLK),
    .i_rst(I_SRST),
    .i_clr(cnt_clr),
    .i_inc_lo(inc[2]),
    .i_inc_hi(inc[3]),
    .i_chain(I_CARRY_SECOND),
    .o_cnt_lo(second_low_counter),
    .o_cnt_hi(second_high_counter),
    .o_ovf_lo(ovf[2]),
    .o_ovf_hi(ovf[3])
  );

  // ****************************************
  // stop lines
  // ****************************************

  // count condition is a wrap; a chained low wrap is internal carry only
  always_comb begin
    stop_cond = ovf & I_STOP_EN;
    if (I_CARRY_FIRST) begin
      stop_cond[0] = 1'b0;
    end
    if (I_CARRY_SECOND) begin
      stop_cond[2] = 1'b0;
    end
  end

  // halt held until released; a new condition wins over release
  always_comb begin
    halt_nxt = halt_r;
    if (I_STOP_RELEASE) begin
      halt_nxt = 1'b0;
    end
    if (|stop_cond) begin
      halt_nxt = 1'b1;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      halt_r <= 1'b0;
    end else begin
      halt_r <= halt_nxt;
    end
  end

  assign O_CPU_HALT = halt_r;

  // ****************************************
  // fault capture
  // ****************************************

  // sticky fault bits; a fault in the clear cycle stays set
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      flt_lo_r <= '0;
    end else if (I_CLR_FAULT) begin
      flt_lo_r <= I_FAULT_LO;
    end else begin
      flt_lo_r <= flt_lo_r | I_FAULT_LO;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      flt_hi_r <= '0;
    end else if (I_CLR_FAULT) begin
      flt_hi_r <= I_FAULT_HI;
    end else begin
      flt_hi_r <= flt_hi_r | I_FAULT_HI;
    end
  end

  // first error-correction fault: address, bus, syndrome and double flag
  always_comb begin
    secded_in.addr = I_SECDED_ADDR;
    secded_in.bus = I_SECDED_BUS;
    secded_in.synd = I_SECDED_SYND;
    secded_in.dbl = I_SECDED_DOUBLE;
  end

  // released only by the single-error clear, not the general clear
  first_capture #(
    .W($bits(secded_cap_t))
  ) u_secded_cap (
    .i_clk(I_MCLK),
    .i_rst(I_SRST),
    .i_capture(I_SECDED_ERR),
    .i_data(secded_in),
    .i_release(I_CLR_SINGLE),
    .o_valid(secded_valid),
    .o_data(secded_held)
  );

  // ****************************************
  // bounds hit capture
  // ****************************************

  // compare on half-word boundaries, low address bits ignored
  assign bounds_hit = I_MEM_ACCESS
                   && ((half_word(I_ACCESS_ADDR) < half_word(I_BOUND_LO))
                    || (half_word(I_ACCESS_ADDR) > half_word(I_BOUND_HI)));

  // first hit held until the general fault clear
  first_capture #(
    .W(BADDR_W)
  ) u_bounds_cap (
    .i_clk(I_MCLK),
    .i_rst(I_SRST),
    .i_capture(bounds_hit),
    .i_data(I_ACCESS_ADDR),
    .i_release(I_CLR_FAULT),
    .o_valid(bounds_valid),
    .o_data(bounds_addr)
  );

  // ****************************************
  // display words
  // ****************************************

  // fault word assembly; microcode address 0-7 lands at 26-33
  always_comb begin
    fault_word.addr = secded_held.addr;
    fault_word.mic = I_MIC_ADDR;
    fault_word.flt_hi = flt_hi_r;
    fault_word.synd = secded_held.synd;
    fault_word.dbl = secded_held.dbl;
    fault_word.flt_lo = flt_lo_r;
    fault_word.bus = secded_held.bus;
  end

  // counters packed low pair first
  always_comb begin
    cnt_word.first_low = first_low_counter;
    cnt_word.first_high = first_high_counter;
    cnt_word.second_low = second_low_counter;
    cnt_word.second_high = second_high_counter;
  end

  // select code decode; unknown codes read zero
  always_comb begin
    disp_nxt = disp_r;
    if (I_DISP_RD) begin
      case (I_DISP_SEL)
        DSEL_FAULT: begin
          disp_nxt = fault_word;
        end
        DSEL_BOUNDS: begin
          disp_nxt = {{(DISP_W-BADDR_W){1'b0}}, bounds_addr};
        end
        DSEL_COUNTERS: begin
          disp_nxt = cnt_word;
        end
        default: begin
          disp_nxt = DISP_RESET;
        end
      endcase
    end
  end

  // display register loads on read; data and valid appear together one cycle later
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      disp_r <= DISP_RESET;
    end else begin
      disp_r <= disp_nxt;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      disp_valid_r <= 1'b0;
    end else begin
      disp_valid_r <= I_DISP_RD;
    end
  end

  assign O_DISP_DATA = disp_r;
  assign O_DISP_VALID = disp_valid_r;

endmodule : event_counters_fault_display
`default_nettype wire

/* File: verification/evt_fault_asserts.sv */
// concurrent checks on display, halt and fault ports of the block
`timescale 1ns/1ps
`default_nettype none
module evt_fault_asserts
  import evt_fault_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_SRST,
  input wire logic [SEL_W-1:0] I_DISP_SEL,
  input wire logic I_DISP_RD,
  input wire logic [DISP_W-1:0] O_DISP_DATA,
  input wire logic O_DISP_VALID,
  input wire logic [CHAN_W-1:0] I_COUNTER_CONTROL_CHANNEL,
  input wire logic [NCNT-1:0] I_COUNT_LINE,
  input wire logic [NCNT-1:0] I_STOP_EN,
  input wire logic I_STOP_RELEASE,
  input wire logic O_CPU_HALT,
  input wire logic I_SECDED_ERR,
  input wire logic [FLT_LO_W-1:0] I_FAULT_LO,
  input wire logic [FLT_HI_W-1:0] I_FAULT_HI,
  input wire logic [MIC_W-1:0] I_MIC_ADDR,
  input wire logic I_CLR_FAULT,
  input wire logic I_CLR_SINGLE
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_SRST);
  fault_word_t fw;
  logic rd_cnt, rd_flt, rd_bnd, no_flt;
  // decoded reads and quiet fault lines
  assign fw = O_DISP_DATA;
  assign rd_cnt = I_DISP_RD && I_DISP_SEL == DSEL_COUNTERS;
  assign rd_flt = I_DISP_RD && I_DISP_SEL == DSEL_FAULT;
  assign rd_bnd = I_DISP_RD && I_DISP_SEL == DSEL_BOUNDS;
  assign no_flt = I_FAULT_LO == '0 && I_FAULT_HI == '0;
  sequence s_clr_rd;
    rd_cnt && !I_COUNTER_CONTROL_CHANNEL[CTRL_HOLD_BIT] ##1 rd_cnt && I_COUNT_LINE == '0;
  endsequence
  sequence s_flt_clr;
    I_CLR_FAULT && no_flt ##1 rd_flt && no_flt;
  endsequence
  sequence s_sgl_clr;
    I_CLR_SINGLE && !I_SECDED_ERR ##1 rd_flt && !I_SECDED_ERR;
  endsequence
  chk_valid_follows: assert property (I_DISP_RD |=> O_DISP_VALID)
    else $error("valid missing after read");
  chk_valid_single: assert property (!I_DISP_RD |=> !O_DISP_VALID)
    else $error("valid without read");
  chk_data_holds: assert property (!I_DISP_RD |=> $stable(O_DISP_DATA))
    else $error("display changed without read");
  chk_bounds_upper: assert property (rd_bnd |=> O_DISP_DATA[63:32] == '0)
    else $error("bounds word upper half not zero");
  chk_mic_field: assert property (rd_flt |=> fw.mic == $past(I_MIC_ADDR))
    else $error("microcode address field wrong");
  chk_clear_read: assert property (s_clr_rd |=> O_DISP_DATA == '0)
    else $error("counters not zeroed after read");
  chk_fault_clear: assert property (s_flt_clr |=> fw.flt_hi == '0 && fw.flt_lo == '0)
    else $error("fault bits survive clear");
  chk_single_clear: assert property (s_sgl_clr |=> fw.addr == '0 && fw.synd == '0 && !fw.dbl)
    else $error("error capture survives single clear");
  chk_halt_sticky: assert property (O_CPU_HALT && !I_STOP_RELEASE |=> O_CPU_HALT)
    else $error("halt dropped without release");
  chk_halt_cause: assert property ($rose(O_CPU_HALT) |-> $past(I_STOP_EN) != '0)
    else $error("halt without stop enable");
endmodule : evt_fault_asserts
bind event_counters_fault_display evt_fault_asserts u_chk (.I_MCLK, .I_SRST, .I_DISP_SEL,
  .I_DISP_RD, .O_DISP_DATA, .O_DISP_VALID, .I_COUNTER_CONTROL_CHANNEL, .I_COUNT_LINE,
  .I_STOP_EN, .I_STOP_RELEASE, .O_CPU_HALT, .I_SECDED_ERR, .I_FAULT_LO, .I_FAULT_HI,
  .I_MIC_ADDR, .I_CLR_FAULT, .I_CLR_SINGLE);
`default_nettype wire

/* File: verification/maint_unit_model.sv */
// maintenance unit model: display reads, event selection, clear strobes
`timescale 1ns/1ps
`default_nettype none
module maint_unit_model
  import evt_fault_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_valid,
  input wire logic [DISP_W-1:0] i_data,
  output logic [SEL_W-1:0] o_disp_sel,
  output logic o_disp_rd,
  output logic [15:0] o_sel,
  output logic [NCNT-1:0] o_count_line,
  output logic o_clr_fault,
  output logic o_clr_single
);
  // ****************************************
  // tasks
  // ****************************************
  initial begin
    {o_disp_sel, o_disp_rd, o_sel, o_count_line, o_clr_fault, o_clr_single} = '0;
  end
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask : tick
  // one read; keep holds the strobe for a back-to-back read
  task automatic rd(input logic [SEL_W-1:0] s, input logic keep, output logic [DISP_W-1:0] d);
    o_disp_sel = s;
    o_disp_rd = 1'b1;
    tick();
    d = (i_valid === 1'b1) ? i_data : 'x;
    if (!keep) begin
      o_disp_rd = 1'b0;
      tick();
    end
  endtask : rd
  // count lines drop before the selection changes
  task automatic choose(input logic [15:0] s, input logic [NCNT-1:0] cl);
    o_count_line = '0;
    tick();
    o_sel = s;
    tick();
    o_count_line = cl;
  endtask : choose
  task automatic clr(input logic single);
    o_clr_single = single;
    o_clr_fault = !single;
    tick();
    o_clr_single = 1'b0;
    o_clr_fault = 1'b0;
  endtask : clr
endmodule : maint_unit_model
`default_nettype wire

/* File: verification/test_event_counters_fault_display.sv */
// self-checking bench for the event counter and fault display block
`timescale 1ns/1ps
`default_nettype none
module test_event_counters_fault_display
  import evt_fault_pkg::*;
;
  // ****************************************
  // harness
  // ****************************************
  typedef struct packed {
    logic [2:0] g;
    logic jce;
    logic jm;
    logic mm;
    logic [3:0] cl;
    logic [15:0] exp;
  } row_t;
  logic clk, rst, carry1, carry2, stop_rel, jce, jm, mm, iss, s_err, s_dbl, acc;
  logic drd, dvalid, halt, clrf, clrs;
  logic [2:0] gate, bus;
  logic [3:0] cl, stop_en;
  logic [4:0] f_lo;
  logic [6:0] synd;
  logic [7:0] dsel, fc, mic;
  logic [9:0] f_hi;
  logic [15:0] ctrl, ev, sels;
  logic [29:0] s_addr;
  logic [31:0] a_addr, b_lo, b_hi;
  logic [63:0] ddata, d;
  func_chan_t func;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [7:0] codes[4] = '{8'hA3, 8'hB0, 8'hAF, 8'h5B};
  logic [31:0] addrs[4] = '{32'h0000_201F, 32'h0000_1000, 32'h0000_0FFF, 32'h0000_3004};
  // gate table: one gate alone, its mode missing, no gate, no count line
  row_t rows[7] = '{{3'b001, 1'b1, 1'b0, 1'b0, 4'h1, 16'h0003},
                    {3'b001, 1'b0, 1'b1, 1'b1, 4'h1, 16'h0000},
                    {3'b010, 1'b0, 1'b1, 1'b0, 4'h1, 16'h0003},
                    {3'b010, 1'b1, 1'b0, 1'b1, 4'h1, 16'h0000},
                    {3'b100, 1'b0, 1'b0, 1'b1, 4'h1, 16'h0003},
                    {3'b000, 1'b1, 1'b1, 1'b1, 4'h1, 16'h0000},
                    {3'b111, 1'b1, 1'b1, 1'b1, 4'h0, 16'h0000}};
  event_counters_fault_display dut (.I_MCLK(clk), .I_SRST(rst), .I_DISP_SEL(dsel),
    .I_DISP_RD(drd), .O_DISP_DATA(ddata), .O_DISP_VALID(dvalid),
    .I_COUNTER_CONTROL_CHANNEL(ctrl), .I_FUNCTION_SELECT_CHANNEL(func), .I_EVENT_LINES(ev),
    .I_SEL_FIRST_LOW(sels[3:0]), .I_SEL_FIRST_HIGH(sels[7:4]),
    .I_SEL_SECOND_LOW(sels[11:8]), .I_SEL_SECOND_HIGH(sels[15:12]), .I_COUNT_LINE(cl),
    .I_CARRY_FIRST(carry1), .I_CARRY_SECOND(carry2), .I_STOP_EN(stop_en),
    .I_STOP_RELEASE(stop_rel), .O_CPU_HALT(halt), .I_GATE_MASK(gate), .I_JOB_CNT_EN(jce),
    .I_JOB_MODE(jm), .I_MONITOR_MODE(mm), .I_INSTR_ISSUE(iss), .I_INSTR_FCODE(fc),
    .I_SECDED_ERR(s_err), .I_SECDED_DOUBLE(s_dbl), .I_SECDED_SYND(synd), .I_SECDED_BUS(bus),
    .I_SECDED_ADDR(s_addr), .I_FAULT_LO(f_lo), .I_FAULT_HI(f_hi), .I_MIC_ADDR(mic),
    .I_CLR_FAULT(clrf), .I_CLR_SINGLE(clrs), .I_MEM_ACCESS(acc), .I_ACCESS_ADDR(a_addr),
    .I_BOUND_LO(b_lo), .I_BOUND_HI(b_hi));
  maint_unit_model p (.i_clk(clk), .i_valid(dvalid), .i_data(ddata), .o_disp_sel(dsel),
    .o_disp_rd(drd), .o_sel(sels), .o_count_line(cl), .o_clr_fault(clrf), .o_clr_single(clrs));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  function automatic fault_word_t mkf(logic [29:0] a, logic [6:0] s, logic db, logic [2:0] bs,
                                      logic [4:0] lo, logic [9:0] hi);
    mkf = '{a, mic, hi, s, db, lo, bs};
  endfunction : mkf
  task automatic summarize();
    if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {carry1, carry2, stop_rel, jce, jm, mm, iss, s_err, s_dbl, acc, func} = '0;
    {gate, bus, stop_en, f_lo, synd, fc, mic, f_hi, ctrl, ev, s_addr, a_addr, b_lo, b_hi} = '0;
    rst = 1'b1;
    repeat (16) tick();
    rst = 1'b0;
    for (int c = 4; c < 8; c++) begin
      p.rd(8'(c), 1'b0, d);
      cmp("reset display", 64'h0, d);
    end
    foreach (rows[i]) begin
      {gate, jce, jm, mm} = {rows[i].g, rows[i].jce, rows[i].jm, rows[i].mm};
      p.choose(16'h0001, rows[i].cl);
      ev = 16'h0002;
      repeat (3) tick();
      ev = '0;
      p.rd(DSEL_COUNTERS, 1'b0, d);
      cmp("gated count", {48'h0, rows[i].exp}, d);
    end
    // each counter on its own line, counter k sees k+1 events
    p.choose(16'h4321, 4'hF);
    for (int j = 0; j < 4; j++) begin
      ev = 16'h001E & (16'hFFFF << (j + 1));
      tick();
    end
    ev = '0;
    p.choose(16'h4321, 4'h0);
    ctrl[CTRL_HOLD_BIT] = 1'b1;
    p.rd(DSEL_COUNTERS, 1'b1, d);
    cmp("packed counters", 64'h0004_0003_0002_0001, d);
    ctrl[CTRL_HOLD_BIT] = 1'b0;
    p.rd(DSEL_COUNTERS, 1'b1, d);
    cmp("held counters", 64'h0004_0003_0002_0001, d);
    p.rd(DSEL_COUNTERS, 1'b0, d);
    cmp("cleared counters", 64'h0, d);
    // function code match on event line 0
    p.choose(16'h0000, 4'h1);
    func = '{mask: 8'hF0, sel: 8'hA0};
    iss = 1'b1;
    foreach (codes[i]) begin
      if (i == 3) func.mask = 8'h00;
      fc = codes[i];
      tick();
    end
    iss = 1'b0;
    p.rd(DSEL_COUNTERS, 1'b0, d);
    cmp("function count", 64'h3, d);
    // first pair chained, second pair wraps alone and halts
    p.choose(16'h0101, 4'h5);
    carry1 = 1'b1;
    stop_en = 4'b0100;
    ev = 16'h0002;
    repeat (65535) tick();
    cmp("halt early", 64'h0, {63'h0, halt});
    repeat (3) tick();
    ev = '0;
    tick();
    cmp("halt set", 64'h1, {63'h0, halt});
    p.rd(DSEL_COUNTERS, 1'b0, d);
    cmp("chained counters", 64'h0000_0002_0001_0002, d);
    stop_rel = 1'b1;
    tick();
    stop_rel = 1'b0;
    tick();
    cmp("halt released", 64'h0, {63'h0, halt});
    // both pairs chained: high counters ignore their own lines
    carry2 = 1'b1;
    p.choose(16'h1111, 4'hF);
    ev = 16'h0002;
    repeat (2) tick();
    ev = '0;
    p.rd(DSEL_COUNTERS, 1'b0, d);
    cmp("chained own lines", 64'h0000_0002_0000_0002, d);
    // every bus code, first error kept over a second one
    mic = 8'hE5;
    for (int b = 0; b < 6; b++) begin
      {s_err, bus, s_addr, synd, s_dbl} = {1'b1, 3'(b), 30'h0000_1000 + 30'(b), 7'h11, b[0]};
      tick();
      {bus, s_addr, synd, s_dbl} = {3'(5 - b), 30'h3FFF_FFFF, 7'h7F, ~b[0]};
      tick();
      s_err = 1'b0;
      p.rd(DSEL_FAULT, 1'b0, d);
      cmp("first fault", mkf(30'h0000_1000 + 30'(b), 7'h11, b[0], 3'(b), 0, 0), d);
      p.clr(1'b1);
    end
    {s_err, bus, s_addr, synd, s_dbl, f_lo, f_hi} = {1'b1, BUS_SCALAR, 30'h2AAA_5555, 7'h05,
                                                     1'b0, 5'h1F, 10'h3FF};
    tick();
    {s_err, f_lo, f_hi} = '0;
    p.rd(DSEL_FAULT, 1'b0, d);
    cmp("sticky faults", mkf(30'h2AAA_5555, 7'h05, 0, BUS_SCALAR, 5'h1F, 10'h3FF), d);
    p.clr(1'b0);
    p.rd(DSEL_FAULT, 1'b0, d);
    cmp("fault clear", mkf(30'h2AAA_5555, 7'h05, 0, BUS_SCALAR, 0, 0), d);
    p.clr(1'b1);
    p.rd(DSEL_FAULT, 1'b0, d);
    cmp("single clear", mkf(0, 0, 0, 0, 0, 0), d);
    // bounds at half-word granularity, first hit held
    {b_lo, b_hi, acc} = {32'h0000_1000, 32'h0000_2000, 1'b1};
    foreach (addrs[i]) begin
      a_addr = addrs[i];
      tick();
    end
    acc = 1'b0;
    p.rd(DSEL_BOUNDS, 1'b0, d);
    cmp("bounds hit", 64'h0000_0000_0000_0FFF, d);
    p.clr(1'b0);
    p.rd(DSEL_BOUNDS, 1'b0, d);
    cmp("bounds released", 64'h0, d);
    summarize();
  end
endmodule : test_event_counters_fault_display
`default_nettype wire
